// [core/fhi_pkg.sv]
// Package of constants and types for the frame handler interrupt flag block
package fhi_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register indices, byte address is four times the index
    localparam logic [7:0] FHI_IDX_FLAGS     = 8'h99;
    localparam logic [7:0] FHI_IDX_ENABLES   = 8'h9a;
    localparam logic [7:0] FHI_IDX_THRESHOLD = 8'ha0;
    localparam logic [7:0] FHI_IDX_PENDING   = 8'ha1;

    ////////////////////////////////////////////////////////////////////////////
    // Bit positions in flags and enables
    localparam int FHI_BIT_RX_ERROR       = 7;
    localparam int FHI_BIT_CYCLE_END      = 6;
    localparam int FHI_BIT_WAKEUP_DONE    = 5;
    localparam int FHI_BIT_TIMEOUT        = 4;
    localparam int FHI_BIT_TX_START       = 3;
    localparam int FHI_BIT_RESPONSE_START = 2;
    localparam int FHI_BIT_RX_LEVEL       = 1;
    localparam int FHI_BIT_MESSAGE_END    = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Widths and reset values
    localparam int         FHI_FLAG_W          = 8;
    localparam int         FHI_ADDR_W          = 10;
    localparam logic [7:0] FHI_FLAGS_RESET     = 8'h00;
    localparam logic [7:0] FHI_ENABLES_RESET   = 8'h00;
    localparam logic [7:0] FHI_THRESHOLD_RESET = 8'h00;

    ////////////////////////////////////////////////////////////////////////////
    // Event inputs from frame handler and receiver
    typedef struct packed {
        logic rx_error;       // Checksum or parity error pulse
        logic cycle_end;      // Cycle timer elapsed pulse
        logic wakeup_busy;    // Wake-up procedure running, level
        logic timeout;        // Timeout pulse
        logic tx_start;       // Master message start pulse
        logic response_start; // Response start bit pulse
        logic rx_byte;        // One device message byte received pulse
        logic message_end;    // Last character received pulse
        logic frame_restart;  // Byte count restart pulse
    } fhi_event_type;

    // Bus state, one-hot
    typedef enum logic [1:0] {
        FHI_ST_IDLE = 2'b01,
        FHI_ST_ACK  = 2'b10
    } fhi_state_type;

endpackage : fhi_pkg

// [core/fhi_flag_bank.sv]
// Sticky flag bank with set-priority clearing
`timescale 1ns/1ps
module fhi_flag_bank (
    input  wire logic                        i_clk,   // System clock
    input  wire logic                        i_nrst,  // Async reset, active low
    input  wire logic [fhi_pkg::FHI_FLAG_W-1:0] i_set,   // Event pulses
    input  wire logic [fhi_pkg::FHI_FLAG_W-1:0] i_clr,   // Bits to clear
    output logic      [fhi_pkg::FHI_FLAG_W-1:0] o_flags  // Sticky flags
);

    ////////////////////////////////////////////////////////////////////////////
    // Set wins over clear in the same cycle
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_flags <= fhi_pkg::FHI_FLAGS_RESET;
        end else begin
            o_flags <= (o_flags & ~i_clr) | i_set;
        end
    end

endmodule : fhi_flag_bank

// [core/fhi_level_counter.sv]
// Received byte counter with threshold detect
`timescale 1ns/1ps
module fhi_level_counter (
    input  wire logic       i_clk,       // System clock
    input  wire logic       i_nrst,      // Async reset, active low
    input  wire logic       i_restart,   // Start counting a new message
    input  wire logic       i_rx_byte,   // One byte received
    input  wire logic [7:0] i_threshold, // Byte count to report, zero off
    output logic            o_hit        // Pulse when count reaches threshold
);

    logic [7:0] count_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Byte count, saturates at all ones
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            count_reg <= 8'h00;
        end else if (i_restart) begin
            count_reg <= 8'h00;
        end else if (i_rx_byte && count_reg != 8'hff) begin
            count_reg <= count_reg + 8'h01;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // One pulse as the count steps onto the threshold
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_hit <= 1'b0;
        end else begin
            o_hit <= !i_restart && i_rx_byte && i_threshold != 8'h00
                     && (count_reg + 8'h01) == i_threshold;
        end
    end

endmodule : fhi_level_counter

// [core/fhi_irq_flags.sv]
// Frame handler interrupt flags with Avalon-MM register slave
//
// Implementation choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module fhi_irq_flags (
    input  wire logic                          i_clk,           // System clock
    input  wire logic                          i_nrst,          // Async reset, active low
    // Avalon-MM slave
    input  wire logic [fhi_pkg::FHI_ADDR_W-1:0] i_avs_address,   // Byte address
    input  wire logic                          i_avs_read,      // Read request
    input  wire logic                          i_avs_write,     // Write request
    input  wire logic [31:0]                   i_avs_writedata, // Write data
    input  wire logic [3:0]                    i_avs_byteenable, // Byte lanes
    output logic      [31:0]                   o_avs_readdata,  // Read data
    output logic                               o_avs_waitrequest, // Stall
    // Events
    input  wire fhi_pkg::fhi_event_type        i_events,        // Event sources
    // Interrupt
    output logic                               o_irq            // Level, active high
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    fhi_pkg::fhi_state_type                state_reg;
    logic [fhi_pkg::FHI_FLAG_W-1:0]        flags;
    logic [fhi_pkg::FHI_FLAG_W-1:0]        enables_reg;
    logic [7:0]                            threshold_reg;
    logic [fhi_pkg::FHI_FLAG_W-1:0]        set_vec;
    logic [fhi_pkg::FHI_FLAG_W-1:0]        clr_vec;
    logic [fhi_pkg::FHI_FLAG_W-1:0]        read_mask_reg;
    logic                                  wakeup_busy_reg;
    logic                                  wakeup_done;
    logic                                  level_hit;
    logic                                  accept;
    logic                                  hit_flags;
    logic                                  hit_enables;
    logic                                  hit_threshold;
    logic                                  hit_pending;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode helper
    function automatic logic fhi_hit(input logic [fhi_pkg::FHI_ADDR_W-1:0] addr,
                                     input logic [7:0] index);
        fhi_hit = addr[1:0] == 2'b00 && addr[fhi_pkg::FHI_ADDR_W-1:2] == index;
    endfunction : fhi_hit

    assign hit_flags     = fhi_hit(i_avs_address, fhi_pkg::FHI_IDX_FLAGS);
    assign hit_enables   = fhi_hit(i_avs_address, fhi_pkg::FHI_IDX_ENABLES);
    assign hit_threshold = fhi_hit(i_avs_address, fhi_pkg::FHI_IDX_THRESHOLD);
    assign hit_pending   = fhi_hit(i_avs_address, fhi_pkg::FHI_IDX_PENDING);

    // Request completes at the edge where waitrequest is low
    assign accept = state_reg == fhi_pkg::FHI_ST_ACK;

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle, then acknowledge
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            state_reg         <= fhi_pkg::FHI_ST_IDLE;
            o_avs_waitrequest <= 1'b1;
        end else begin
            case (state_reg)
                fhi_pkg::FHI_ST_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        state_reg         <= fhi_pkg::FHI_ST_ACK;
                        o_avs_waitrequest <= 1'b0;
                    end
                end
                fhi_pkg::FHI_ST_ACK: begin
                    state_reg         <= fhi_pkg::FHI_ST_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    state_reg         <= fhi_pkg::FHI_ST_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read data captured one cycle ahead, zero when unmapped
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_avs_readdata <= 32'h0000_0000;
            read_mask_reg  <= 8'h00;
        end else if (state_reg == fhi_pkg::FHI_ST_IDLE && i_avs_read) begin
            read_mask_reg  <= hit_flags ? flags : 8'h00;
            if (hit_flags) begin
                o_avs_readdata <= {24'h00_0000, flags};
            end else if (hit_enables) begin
                o_avs_readdata <= {24'h00_0000, enables_reg};
            end else if (hit_threshold) begin
                o_avs_readdata <= {24'h00_0000, threshold_reg};
            end else if (hit_pending) begin
                o_avs_readdata <= {24'h00_0000, flags & enables_reg};
            end else begin
                o_avs_readdata <= 32'h0000_0000;
            end
        end else if (accept) begin
            read_mask_reg  <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Enable register, low byte lane only
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            enables_reg <= fhi_pkg::FHI_ENABLES_RESET;
        end else if (accept && i_avs_write && hit_enables && i_avs_byteenable[0]) begin
            enables_reg <= i_avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Received byte threshold register
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            threshold_reg <= fhi_pkg::FHI_THRESHOLD_RESET;
        end else if (accept && i_avs_write && hit_threshold && i_avs_byteenable[0]) begin
            threshold_reg <= i_avs_writedata[7:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Wake-up finish seen as busy falling
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            wakeup_busy_reg <= 1'b0;
        end else begin
            wakeup_busy_reg <= i_events.wakeup_busy;
        end
    end

    assign wakeup_done = wakeup_busy_reg && !i_events.wakeup_busy;

    ////////////////////////////////////////////////////////////////////////////
    // Byte level detection
    fhi_level_counter u_level (
        .i_clk       (i_clk),
        .i_nrst      (i_nrst),
        .i_restart   (i_events.frame_restart),
        .i_rx_byte   (i_events.rx_byte),
        .i_threshold (threshold_reg),
        .o_hit       (level_hit)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Event vector in flag order
    always_comb begin
        set_vec                                  = 8'h00;
        set_vec[fhi_pkg::FHI_BIT_RX_ERROR]       = i_events.rx_error;
        set_vec[fhi_pkg::FHI_BIT_CYCLE_END]      = i_events.cycle_end;
        set_vec[fhi_pkg::FHI_BIT_WAKEUP_DONE]    = wakeup_done;
        set_vec[fhi_pkg::FHI_BIT_TIMEOUT]        = i_events.timeout;
        set_vec[fhi_pkg::FHI_BIT_TX_START]       = i_events.tx_start;
        set_vec[fhi_pkg::FHI_BIT_RESPONSE_START] = i_events.response_start;
        set_vec[fhi_pkg::FHI_BIT_RX_LEVEL]       = level_hit;
        set_vec[fhi_pkg::FHI_BIT_MESSAGE_END]    = i_events.message_end;
    end

    ////////////////////////////////////////////////////////////////////////////
    // Clear flags that were read from the flag register, or written as one
    always_comb begin
        clr_vec = 8'h00;
        if (accept && i_avs_read) begin
            clr_vec = read_mask_reg;
        end else if (accept && i_avs_write && hit_flags && i_avs_byteenable[0]) begin
            clr_vec = i_avs_writedata[7:0];
        end
    end

    fhi_flag_bank u_flags (
        .i_clk   (i_clk),
        .i_nrst  (i_nrst),
        .i_set   (set_vec),
        .i_clr   (clr_vec),
        .o_flags (flags)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Interrupt request, registered
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= |(flags & enables_reg);
        end
    end

endmodule : fhi_irq_flags

// [verification/fhi_properties.sv]
// Checker for bus timing, read data and interrupt level at the block ports
`timescale 1ns/1ps
module fhi_irq_flags_checker (
    input wire logic                  i_clk,             // System clock
    input wire logic                  i_nrst,            // Async reset, active low
    input wire logic [9:0]            i_avs_address,     // Byte address
    input wire logic                  i_avs_read,        // Read request
    input wire logic                  i_avs_write,       // Write request
    input wire logic [31:0]           i_avs_writedata,   // Write data
    input wire logic [3:0]            i_avs_byteenable,  // Byte lanes
    input wire logic [31:0]           o_avs_readdata,    // Read data
    input wire logic                  o_avs_waitrequest, // Stall
    input wire fhi_pkg::fhi_event_type i_events,         // Event sources
    input wire logic                  o_irq              // Interrupt
);
    logic [7:0] en_shadow_reg;
    logic       done;
    assign done = !o_avs_waitrequest;

    ////////////////////////////////////////////////////////////////////////////
    // Shadow of the enable register from completed writes
    always_ff @(posedge i_clk or negedge i_nrst) begin
        if (!i_nrst) en_shadow_reg <= 8'h00;
        else if (i_avs_write && done && i_avs_address == 10'h268 && i_avs_byteenable[0])
            en_shadow_reg <= i_avs_writedata[7:0];
    end

    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_nrst);

    ////////////////////////////////////////////////////////////////////////////
    a_ack_once: assert property ($fell(o_avs_waitrequest) |=> o_avs_waitrequest)
        else $error("ack held longer than one cycle");
    a_ack_request: assert property (done |-> (i_avs_read || i_avs_write))
        else $error("ack without request");
    a_ack_latency: assert property ($rose(i_avs_read || i_avs_write) |-> ##[1:2] done)
        else $error("ack late");
    a_reset_state: assert property ($rose(i_nrst) |-> o_avs_waitrequest && !o_irq)
        else $error("bad state after reset");
    a_upper_zero: assert property (done && i_avs_read |-> o_avs_readdata[31:8] == 24'h0)
        else $error("upper read bits set");
    a_unmapped_zero: assert property (done && i_avs_read
        && !(i_avs_address inside {10'h264, 10'h268, 10'h280, 10'h284})
        |-> o_avs_readdata == 32'h0)
        else $error("unmapped read not zero");
    a_enable_readback: assert property (done && i_avs_read && i_avs_address == 10'h268
        |-> o_avs_readdata[7:0] == en_shadow_reg)
        else $error("enable readback wrong");
    a_irq_masked: assert property (en_shadow_reg == 8'h00 && $past(en_shadow_reg) == 8'h00
        |-> !o_irq)
        else $error("irq with all enables off");
    a_irq_raise: assert property (i_events.rx_error && en_shadow_reg[7] |-> ##[1:2] o_irq)
        else $error("irq missing after enabled event");
endmodule : fhi_irq_flags_checker

bind fhi_irq_flags fhi_irq_flags_checker u_chk (.i_clk(i_clk), .i_nrst(i_nrst),
    .i_avs_address(i_avs_address), .i_avs_read(i_avs_read), .i_avs_write(i_avs_write),
    .i_avs_writedata(i_avs_writedata), .i_avs_byteenable(i_avs_byteenable),
    .o_avs_readdata(o_avs_readdata), .o_avs_waitrequest(o_avs_waitrequest),
    .i_events(i_events), .o_irq(o_irq));

// [verification/fhi_source_model.sv]
// Frame handler event source model, registered event pulses and wake-up busy level
`timescale 1ns/1ps
module fhi_source_model (
    input  wire logic             i_clk,     // System clock
    input  wire logic [7:0]       i_fire,    // Event request per flag bit, bit 5 unused
    input  wire logic             i_busy,    // Wake-up running
    input  wire logic             i_restart, // New message
    output fhi_pkg::fhi_event_type o_events  // Events to block
);
    // Map requests onto event lines, one cycle later
    always_ff @(posedge i_clk) begin
        o_events <= {i_fire[7:6], i_busy, i_fire[4:0], i_restart};
    end
endmodule : fhi_source_model

// [verification/tb.sv]
// Self-checking bench for the frame handler interrupt flag block
`timescale 1ns/1ps
module tb;
    logic                   i_clk = 0, i_nrst = 0, rd = 0, wr = 0, wreq, irq;
    logic                   busy = 0, rstc = 0;
    logic [9:0]             adr = 10'h000;
    logic [31:0]            wd = 32'h0, rdata, got;
    logic [3:0]             be = 4'h0;
    logic [7:0]             fire = 8'h00;
    fhi_pkg::fhi_event_type ev;
    int                     n_fail = 0, checks_done = 0;

    always #5 i_clk = ~i_clk;
    fhi_source_model PM (.i_clk(i_clk), .i_fire(fire), .i_busy(busy), .i_restart(rstc),
        .o_events(ev));
    fhi_irq_flags DUT (.i_clk(i_clk), .i_nrst(i_nrst), .i_avs_address(adr), .i_avs_read(rd),
        .i_avs_write(wr), .i_avs_writedata(wd), .i_avs_byteenable(be), .o_avs_readdata(rdata),
        .o_avs_waitrequest(wreq), .i_events(ev), .o_irq(irq));

    ////////////////////////////////////////////////////////////////////////////
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : close_out
    task automatic cmp(input logic [31:0] g, input logic [31:0] e);
        checks_done++;
        if (g !== e) begin
            n_fail++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask : cmp
    // One bus cycle, held until waitrequest is sampled low
    task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d);
        rd <= !w; wr <= w; adr <= a; wd <= d; be <= 4'h1;
        @(posedge i_clk iff (wreq === 1'b0));
        got = rdata;
        rd <= 1'b0; wr <= 1'b0;
        @(posedge i_clk);
    endtask : bus
    task automatic pulse(input logic [7:0] m);
        fire <= m;
        @(posedge i_clk);
        fire <= 8'h00;
        repeat (3) @(posedge i_clk);
    endtask : pulse
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        bus(0, 10'h264, 0); cmp(got, 32'h0);
        bus(0, 10'h268, 0); cmp(got, 32'h0);
        bus(1, 10'h3fc, 32'hff); bus(0, 10'h3fc, 0); cmp(got, 32'h0);
    endtask : t_reset
    task automatic t_events();
        foreach (fire[b]) if (b != 5 && b != 1) begin
            pulse(8'h01 << b);
            bus(0, 10'h264, 0); cmp(got, 32'h1 << b);
            bus(0, 10'h264, 0); cmp(got, 32'h0);
        end
    endtask : t_events
    task automatic t_wake_level();
        busy <= 1'b1; repeat (3) @(posedge i_clk);
        bus(0, 10'h264, 0); cmp(got, 32'h0);
        busy <= 1'b0; repeat (3) @(posedge i_clk);
        bus(0, 10'h264, 0); cmp(got, 32'h20);
        bus(1, 10'h280, 32'h3); bus(0, 10'h280, 0); cmp(got, 32'h3);
        rstc <= 1'b1; @(posedge i_clk); rstc <= 1'b0;
        pulse(8'h02); pulse(8'h02); bus(0, 10'h264, 0); cmp(got, 32'h0);
        pulse(8'h02); repeat (2) @(posedge i_clk);
        bus(0, 10'h264, 0); cmp(got, 32'h02);
    endtask : t_wake_level
    task automatic t_irq();
        bus(1, 10'h268, 32'hff); pulse(8'h80); cmp(irq, 1);
        bus(0, 10'h268, 0); cmp(got, 32'hff);
        bus(0, 10'h284, 0); cmp(got, 32'h80);
        bus(1, 10'h268, 32'h00); repeat (2) @(posedge i_clk); cmp(irq, 0);
        bus(1, 10'h268, 32'h80); repeat (2) @(posedge i_clk); cmp(irq, 1);
        bus(0, 10'h264, 0); cmp(got, 32'h80);
        repeat (2) @(posedge i_clk); cmp(irq, 0);
    endtask : t_irq
    task automatic t_same_cycle();
        pulse(8'h80);
        // Same bit and a new bit land on the clearing edge
        fork
            bus(0, 10'h264, 0);
            pulse(8'h88);
        join
        cmp(got, 32'h80);
        bus(0, 10'h264, 0); cmp(got, 32'h88);
        // Writing a one clears only that flag
        pulse(8'h18); bus(1, 10'h264, 32'h10);
        bus(0, 10'h264, 0); cmp(got, 32'h08);
    endtask : t_same_cycle

    ////////////////////////////////////////////////////////////////////////////
    // Main sequence and watchdog
    initial begin
        repeat (16) @(posedge i_clk);
        i_nrst <= 1'b1;
        @(posedge i_clk);
        t_reset(); t_events(); t_wake_level(); t_irq(); t_same_cycle();
        close_out();
    end
    initial begin
        #50us;
        n_fail++;
        close_out();
    end
endmodule : tb
